// [logic/spl_sector_protect.sv]
/*
 * Sector protection logic: persistent and dynamic lock bits,
 * lock guard, one-time configuration word, APB slave.
 * Assumes NPOR is low at power-up together with NRST, and
 * that the password comparison lives outside (PASSWORD_OK).
 */
`timescale 1ns/1ps

// Operation
// - Persistent lock 0 refuses program and erase; here only array program exists, no erase command
// - Persistent bits programmed singly, erased together
// - Status readable during lock bit operations
// - Guard 0 aborts persistent changes, flags
// - Lock status read only inside overlay
// - Dynamic set writes 0, clear writes 1
// - Dynamic bits unprotected after reset
// - Unprotected only when both bits are 1
// - Dynamic always changeable, persistent needs guard
// - Bit 13 selects single-error trap
// - Bit 11 selects hybrid or wrapped bursts
// - Bit 9 selects correction control or detection
// - Bit 5 at 0 enables read password
// - Bits 2:1 decode protection mode, freeze
// - Both mode locks at once aborts, flags
// - Config frozen after a mode lock
// - Password mode: resets and lock command clear guard
// - Config program takes word time, status reports
// - Persistent mode: guard 1 at reset, clear only
// - Factory state: persistent mode, all unprotected
// - Password mode: guard 0, unlock sets it
// - Software reset leaves guard unchanged
// - Protected target program sets both flags
module spl_sector_protect #(
    parameter int PROG_CYC  = spl_pkg::PROG_CYCLES,  // Word program
    parameter int ERASE_CYC = spl_pkg::ERASE_CYCLES  // Group erase
) (
    input  wire logic        REF_CLK,       // 50 MHz clock
    input  wire logic        NRST,          // Hardware reset
    input  wire logic        NPOR,          // Power-on reset
    input  wire logic        PSEL,          // APB select
    input  wire logic        PENABLE,       // APB access phase
    input  wire logic        PWRITE,        // APB direction
    input  wire logic [7:0]  PADDR,         // APB byte address
    input  wire logic [31:0] PWDATA,        // APB write data
    output logic [31:0]      PRDATA,        // APB read data
    output logic             PREADY,        // APB ready
    output logic             PSLVERR,       // APB error
    input  wire logic        PASSWORD_OK,   // Password matched
    output logic [15:0]      SECTOR_UNPROT, // Writable sectors
    output logic             ARRAY_GRANT,   // Array program go
    output logic             TRAP_SINGLE,   // Trap 1-bit errors
    output logic             HYBRID_BURST,  // Hybrid bursts
    output logic             DED_ENABLE,    // Double detect on
    output logic             ECC_ONOFF_EN,  // Correction control
    output logic             READ_PW_EN     // Read password mode
);
    // ==========================================================
    // Declarations
    spl_pkg::spl_state_type state_q, state_d;   // Busy sequencer
    spl_pkg::spl_cmd_type   cmd;                // Command view
    logic [15:0] pers_q, pers_d;     // persistent_sector_lock
    logic [15:0] dyn_q, dyn_d;       // dynamic_sector_lock
    logic [15:0] cfg_q, cfg_d;       // protection_config_word
    logic        guard_q, guard_d;   // lock_guard_bit
    logic        init_q, init_d;     // Guard loaded after reset
    logic        aso_q, aso_d;       // address_space_overlay
    logic        lsr_q, lsr_d;       // Lock status result
    logic        lsv_q, lsv_d;       // Lock status valid
    logic        pfail_q, pfail_d;   // program_fail_flag
    logic        lfail_q, lfail_d;   // sector_lock_fail_flag
    logic        efail_q, efail_d;   // Erase failure
    logic        grant_q, grant_d;   // Array grant pulse
    logic [3:0]  sec_q, sec_d;       // Pending sector
    logic [15:0] pmask_q, pmask_d;   // Pending config bits
    logic [spl_pkg::TMR_W-1:0] tmr_q, tmr_d;  // Operation timer
    logic [31:0] rdata_q;            // Registered read data

    // ==========================================================
    // Decoding
    wire        apb_wr    = PSEL & PENABLE & PWRITE;
    wire        apb_rd    = PSEL & ~PWRITE;
    wire        hit_cmd   = PADDR == spl_pkg::OFS_CMD;
    wire        mapped    = (PADDR[1:0] == 2'h0)
                          & (PADDR <= spl_pkg::OFS_GUARD);
    wire        idle      = state_q == spl_pkg::ST_IDLE;
    // Commands taken only while idle and after guard load
    wire        cmd_fire  = apb_wr & hit_cmd & idle & init_q;
    wire        pw_mode   = cfg_q[2:1] == 2'h1;
    wire        frozen    = cfg_q[2:1] != 2'h3;
    wire [15:0] unprot    = pers_q & dyn_q;
    wire        sec_open  = unprot[cmd.sector];
    wire [15:0] new_bits  = ~cmd.data & spl_pkg::CFG_WRITABLE;
    wire        both_lock = new_bits[spl_pkg::CFG_PWL]
                          & new_bits[spl_pkg::CFG_PSL];
    wire        tmr_zero  = tmr_q == '0;
    wire [spl_pkg::TMR_W-1:0] prog_ld  = spl_pkg::TMR_W'(PROG_CYC - 1);
    wire [spl_pkg::TMR_W-1:0] erase_ld = spl_pkg::TMR_W'(ERASE_CYC - 1);
    wire        busy_w    = ~idle;
    wire [31:0] status_w  = {24'h0, ~busy_w, 1'b0, efail_q, pfail_q,
                             2'h0, lfail_q, busy_w};

    assign cmd = spl_pkg::spl_cmd_type'(PWDATA);

    // ==========================================================
    // Read data selection
    logic [31:0] rsel;  // Word for the addressed register
    always_comb begin
        case (PADDR)
            spl_pkg::OFS_STATUS: rsel = status_w;
            spl_pkg::OFS_CFG:    rsel = {16'h0, cfg_q};
            spl_pkg::OFS_PERS:   rsel = {16'h0, pers_q};
            spl_pkg::OFS_DYN:    rsel = {16'h0, dyn_q};
            spl_pkg::OFS_UNPROT: rsel = {16'h0, unprot};
            spl_pkg::OFS_GUARD:  rsel = {28'h0, lsv_q, lsr_q,
                                         aso_q, guard_q};
            default:             rsel = 32'h0;
        endcase
    end

    // ==========================================================
    // Outputs; slave answers in the access cycle
    assign PREADY        = 1'b1;
    assign PSLVERR       = PSEL & PENABLE & ~mapped;
    assign PRDATA        = rdata_q;
    assign SECTOR_UNPROT = unprot;
    assign ARRAY_GRANT   = grant_q;
    assign TRAP_SINGLE   = ~cfg_q[spl_pkg::CFG_TRAP];
    assign HYBRID_BURST  = ~cfg_q[spl_pkg::CFG_HYB];
    assign DED_ENABLE    = ~cfg_q[spl_pkg::CFG_DED];
    assign ECC_ONOFF_EN  = cfg_q[spl_pkg::CFG_DED];
    assign READ_PW_EN    = ~cfg_q[spl_pkg::CFG_RPW];

    // ==========================================================
    // Command decode and busy sequencer
    always_comb begin
        state_d = state_q;
        pers_d  = pers_q;
        dyn_d   = dyn_q;
        cfg_d   = cfg_q;
        guard_d = guard_q;
        init_d  = 1'b1;
        aso_d   = aso_q;
        lsr_d   = lsr_q;
        lsv_d   = lsv_q;
        pfail_d = pfail_q;
        lfail_d = lfail_q;
        efail_d = efail_q;
        grant_d = 1'b0;
        sec_d   = sec_q;
        pmask_d = pmask_q;
        tmr_d   = tmr_zero ? tmr_q : tmr_q - 1'b1;
        // Guard follows the mode in the first cycle after reset
        if (!init_q) begin
            guard_d = ~pw_mode;
        end
        case (state_q)
            spl_pkg::ST_IDLE: begin
                if (cmd_fire) begin
                    case (cmd.opcode)
                        spl_pkg::OP_PERS_PROG: begin
                            if (!guard_q) begin
                                pfail_d = 1'b1;
                                lfail_d = 1'b1;
                            end else begin
                                sec_d   = cmd.sector;
                                tmr_d   = prog_ld;
                                state_d = spl_pkg::ST_PERS_PROG;
                            end
                        end
                        spl_pkg::OP_PERS_ERASE: begin
                            if (!guard_q) begin
                                efail_d = 1'b1;
                                lfail_d = 1'b1;
                            end else begin
                                tmr_d   = prog_ld;
                                state_d = spl_pkg::ST_PRE_PROG;
                            end
                        end
                        // Dynamic bits ignore the guard
                        spl_pkg::OP_DYN_SET:   dyn_d[cmd.sector] = 1'b0;
                        spl_pkg::OP_DYN_CLEAR: dyn_d[cmd.sector] = 1'b1;
                        spl_pkg::OP_GUARD_LOCK: guard_d = 1'b0;
                        spl_pkg::OP_UNLOCK: begin
                            // Unlock sets the guard only on a password match in password mode
                            if (pw_mode && PASSWORD_OK) begin
                                guard_d = 1'b1;
                            end else begin
                                pfail_d = 1'b1;
                                lfail_d = 1'b1;
                            end
                        end
                        spl_pkg::OP_CFG_PROG: begin
                            if (both_lock || frozen) begin
                                pfail_d = 1'b1;
                                lfail_d = 1'b1;
                            end else begin
                                pmask_d = new_bits;
                                tmr_d   = prog_ld;
                                state_d = spl_pkg::ST_CFG_PROG;
                            end
                        end
                        spl_pkg::OP_ASO_ENTER: aso_d = 1'b1;
                        spl_pkg::OP_ASO_EXIT: begin
                            aso_d = 1'b0;
                            lsv_d = 1'b0;
                        end
                        spl_pkg::OP_LOCK_READ: begin
                            // Outside the overlay the read is ignored
                            if (aso_q) begin
                                lsr_d = pers_q[cmd.sector];
                                lsv_d = 1'b1;
                            end
                        end
                        spl_pkg::OP_SOFT_RESET: begin
                            aso_d   = 1'b0;
                            lsv_d   = 1'b0;
                            pfail_d = 1'b0;
                            lfail_d = 1'b0;
                            efail_d = 1'b0;
                        end
                        spl_pkg::OP_CLR_STATUS: begin
                            pfail_d = 1'b0;
                            lfail_d = 1'b0;
                            efail_d = 1'b0;
                        end
                        spl_pkg::OP_ARRAY_PROG: begin
                            if (sec_open) begin
                                grant_d = 1'b1;
                            end else begin
                                pfail_d = 1'b1;
                                lfail_d = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            spl_pkg::ST_PERS_PROG: begin
                if (tmr_zero) begin
                    pers_d[sec_q] = 1'b0;
                    state_d       = spl_pkg::ST_IDLE;
                end
            end
            spl_pkg::ST_PRE_PROG: begin
                // Pre-program every bit so the erase is even
                if (tmr_zero) begin
                    pers_d  = 16'h0000;
                    state_d = spl_pkg::ST_VERIFY;
                end
            end
            spl_pkg::ST_VERIFY: begin
                if (pers_q == 16'h0000) begin
                    tmr_d   = erase_ld;
                    state_d = spl_pkg::ST_ERASE;
                end else begin
                    efail_d = 1'b1;
                    state_d = spl_pkg::ST_IDLE;
                end
            end
            spl_pkg::ST_ERASE: begin
                if (tmr_zero) begin
                    pers_d  = 16'hFFFF;
                    state_d = spl_pkg::ST_IDLE;
                end
            end
            spl_pkg::ST_CFG_PROG: begin
                // One-time bits only move from 1 to 0
                if (tmr_zero) begin
                    cfg_d   = cfg_q & ~pmask_q;
                    state_d = spl_pkg::ST_IDLE;
                end
            end
            default: state_d = spl_pkg::ST_IDLE;
        endcase
    end

    // ==========================================================
    // Non-volatile storage, cleared only at power-on
    always_ff @(posedge REF_CLK or negedge NPOR) begin
        if (!NPOR) begin
            pers_q <= 16'hFFFF;
            cfg_q  <= spl_pkg::CFG_DEFAULT;
        end else begin
            pers_q <= pers_d;
            cfg_q  <= cfg_d;
        end
    end

    // ==========================================================
    // Volatile control state
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= spl_pkg::ST_IDLE;
            dyn_q   <= 16'hFFFF;
            guard_q <= 1'b0;
            init_q  <= 1'b0;
            aso_q   <= 1'b0;
            lsr_q   <= 1'b0;
            lsv_q   <= 1'b0;
            grant_q <= 1'b0;
            sec_q   <= 4'h0;
            pmask_q <= 16'h0000;
            tmr_q   <= '0;
        end else begin
            state_q <= state_d;
            dyn_q   <= dyn_d;
            guard_q <= guard_d;
            init_q  <= init_d;
            aso_q   <= aso_d;
            lsr_q   <= lsr_d;
            lsv_q   <= lsv_d;
            grant_q <= grant_d;
            sec_q   <= sec_d;
            pmask_q <= pmask_d;
            tmr_q   <= tmr_d;
        end
    end

    // ==========================================================
    // Status flags and read data
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pfail_q <= 1'b0;
            lfail_q <= 1'b0;
            efail_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            pfail_q <= pfail_d;
            lfail_q <= lfail_d;
            efail_q <= efail_d;
            // Captured in setup so it is valid in the access cycle
            if (apb_rd && !PENABLE) begin
                rdata_q <= rsel;
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    wire op_pp = cmd_fire & (cmd.opcode == spl_pkg::OP_PERS_PROG);
    wire op_cf = cmd_fire & (cmd.opcode == spl_pkg::OP_CFG_PROG);
    wire op_ap = cmd_fire & (cmd.opcode == spl_pkg::OP_ARRAY_PROG);

    sequence s_preprog_done;
        (state_q == spl_pkg::ST_PRE_PROG) && tmr_zero;
    endsequence
    sequence s_erase_start;
        ##1 (state_q == spl_pkg::ST_VERIFY && pers_q == 16'h0000)
        ##1 (state_q == spl_pkg::ST_ERASE);
    endsequence

    // Either lock bit at 0 must block the array grant
    a_prot_both: assert property (op_ap && !(pers_q[cmd.sector] && dyn_q[cmd.sector])
        |=> !ARRAY_GRANT && pfail_q && lfail_q)
        else $error("protected sector was granted");
    a_guard_abort: assert property (op_pp && !guard_q |=>
        pfail_q && lfail_q && idle && $stable(pers_q))
        else $error("persistent program ran with guard 0");
    a_prog_hold: assert property (state_q == spl_pkg::ST_PERS_PROG
        && !tmr_zero |=> $stable(pers_q))
        else $error("persistent bit changed before program time");
    a_erase_seq: assert property (s_preprog_done |-> s_erase_start)
        else $error("erase did not follow pre-program and verify");
    a_dyn_reset: assert property (!init_q |-> dyn_q == 16'hFFFF)
        else $error("dynamic bits not unprotected after reset");
    a_guard_init: assert property ($rose(init_q) |-> guard_q == ~pw_mode)
        else $error("guard not loaded from protection mode");
    a_guard_noset: assert property (init_q && !pw_mode && !guard_q
        |=> !guard_q)
        else $error("guard rose in persistent mode");
    a_cfg_both: assert property (op_cf && both_lock |=>
        pfail_q && lfail_q && idle)
        else $error("both mode locks were not refused");
    a_cfg_frozen: assert property (op_cf && frozen |=>
        pfail_q && lfail_q && $stable(cfg_q))
        else $error("frozen config word accepted a program");
    a_busy_status: assert property (busy_w && apb_rd && !PENABLE && PADDR == spl_pkg::OFS_STATUS
        |=> PRDATA[0] && !PRDATA[spl_pkg::ST_READY])
        else $error("status read while busy did not show busy");
    a_soft_guard: assert property (cmd_fire
        && cmd.opcode == spl_pkg::OP_SOFT_RESET |=> $stable(guard_q))
        else $error("software reset changed the guard");
    a_rsvd_cfg: assert property (((cfg_q ^ spl_pkg::CFG_DEFAULT)
        & ~spl_pkg::CFG_WRITABLE) == 16'h0)
        else $error("reserved config bit moved");
endmodule // spl_sector_protect

// [logic/spl_pkg.sv]
/*
 * Package for the sector protection block: register map,
 * command codes, configuration word layout, timing counts.
 * Assumes an APB master with 32-bit data on REF_CLK.
 */
package spl_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_SECTORS = 16;   // Protected sectors
    localparam int TMR_W       = 26;   // Fits the erase count

    // ==========================================================
    // Timing
    localparam int CLK_MHZ       = 50;   // REF_CLK rate
    localparam int PROG_TIME_US  = 500;  // Word program time
    localparam int ERASE_TIME_MS = 930;  // Sector erase time
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES  = ERASE_TIME_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00; // Command, write
    localparam logic [7:0] OFS_STATUS = 8'h04; // Status flags
    localparam logic [7:0] OFS_CFG    = 8'h08; // Config word
    localparam logic [7:0] OFS_PERS   = 8'h0C; // Persistent locks
    localparam logic [7:0] OFS_DYN    = 8'h10; // Dynamic locks
    localparam logic [7:0] OFS_UNPROT = 8'h14; // Unprotected map
    localparam logic [7:0] OFS_GUARD  = 8'h18; // Guard and overlay

    // ==========================================================
    // Status bit positions
    localparam int ST_LOCK_FAIL = 1;  // sector_lock_fail_flag
    localparam int ST_PROG_FAIL = 4;  // program_fail_flag
    localparam int ST_ERAS_FAIL = 5;  // Erase failure
    localparam int ST_READY     = 7;  // Device ready

    // ==========================================================
    // Configuration word layout
    localparam int CFG_TRAP = 13;  // single_error_trap_enable
    localparam int CFG_HYB  = 11;  // hybrid_burst_select
    localparam int CFG_DED  = 9;   // double_error_detect_select
    localparam int CFG_RPW  = 5;   // read_password_enable
    localparam int CFG_PWL  = 2;   // password_mode_lock
    localparam int CFG_PSL  = 1;   // persistent_mode_lock
    localparam logic [15:0] CFG_DEFAULT  = 16'hFEFF; // Factory
    localparam logic [15:0] CFG_WRITABLE = 16'h2A26; // OTP bits

    // ==========================================================
    // Command codes
    localparam logic [3:0] OP_PERS_PROG  = 4'h1;
    localparam logic [3:0] OP_PERS_ERASE = 4'h2;
    localparam logic [3:0] OP_DYN_SET    = 4'h3;
    localparam logic [3:0] OP_DYN_CLEAR  = 4'h4;
    localparam logic [3:0] OP_GUARD_LOCK = 4'h5;
    localparam logic [3:0] OP_UNLOCK     = 4'h6;
    localparam logic [3:0] OP_CFG_PROG   = 4'h7;
    localparam logic [3:0] OP_ASO_ENTER  = 4'h8;
    localparam logic [3:0] OP_ASO_EXIT   = 4'h9;
    localparam logic [3:0] OP_LOCK_READ  = 4'hA;
    localparam logic [3:0] OP_SOFT_RESET = 4'hB;
    localparam logic [3:0] OP_CLR_STATUS = 4'hC;
    localparam logic [3:0] OP_ARRAY_PROG = 4'hD;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [15:0] data;    // Config bits to program
        logic [3:0]  rsvd;    // Unused
        logic [3:0]  sector;  // Target sector
        logic [3:0]  rsvd2;   // Unused
        logic [3:0]  opcode;  // Command
    } spl_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PERS_PROG, ST_PRE_PROG,
        ST_VERIFY, ST_ERASE, ST_CFG_PROG
    } spl_state_type;
endpackage

// [test/spl_host_model.sv]
/*
 * APB host model for the sector protection bench: one-word transfers.
 * Assumes one clock; callers enter a transfer just after a rising edge.
 */
`timescale 1ns/1ps
// ==========================================================
// Host model
module spl_host_model (
    input  wire logic        clk,     // Bus clock
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pready,  // Slave ready
    input  wire logic        pslverr, // Slave error
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Direction
    output logic [7:0]       paddr,   // Byte address
    output logic [31:0]      pwdata   // Write data
);
    int   hang_cnt = 0;    // Waits that ran out
    logic err_q    = 1'b0; // Error of last transfer
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr  = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, access held until ready, then release with scrambled lines
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hang_cnt += int'(n >= 64);
        q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;   // Stale address must not look valid
        pwdata  <= ~d;
        @(posedge clk);
    endtask
endmodule // spl_host_model

// [test/tb_top.sv]
/*
 * Self-checking bench for the sector protection block.
 * Assumes the host model for bus cycles; shortened program times.
 */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
// ==========================================================
// Top
module tb_top;
    logic        ref_clk = 1'b0; // 50 MHz
    logic        nrst    = 1'b0; // Hardware reset
    logic        npor    = 1'b0; // Power-on reset
    logic        psel, penable, pwrite, pready, pslverr, grant;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [15:0] unprot;
    wire  [4:0]  cfg_o;          // Trap, hybrid, detect, on-off, read password
    logic [63:0] rows [22];      // {op, sector, data, addr, mask, expected}
    logic        pw_ok   = 1'b0; // Outside password compare result
    int          error_cnt = 0, total_checks = 0;
    int          grant_cnt = 0;  // Array grant pulses seen
    always #10 ref_clk = ~ref_clk;
    // Count one-cycle grant pulses at every rising edge so none is missed
    always @(posedge ref_clk) grant_cnt <= grant_cnt + int'(grant);
    spl_host_model host (.clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    spl_sector_protect #(.PROG_CYC(8), .ERASE_CYC(16)) DUT (.REF_CLK(ref_clk), .NRST(nrst), .NPOR(npor),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PASSWORD_OK(pw_ok), .SECTOR_UNPROT(unprot), .ARRAY_GRANT(grant),
        .TRAP_SINGLE(cfg_o[4]), .HYBRID_BURST(cfg_o[3]), .DED_ENABLE(cfg_o[2]), .ECC_ONOFF_EN(cfg_o[1]),
        .READ_PW_EN(cfg_o[0]));
    // Issue a command, then poll status until idle and ready
    task automatic cmd(input logic [3:0] op, input logic [3:0] s, input logic [15:0] d);
        int n;
        n = 0;
        host.xfer(1'b1, spl_pkg::OFS_CMD, {d, 4'h0, s, 4'h0, op}, rd_q);
        do begin
            host.xfer(1'b0, spl_pkg::OFS_STATUS, 32'h0, rd_q);
            n++;
        end while ((rd_q[spl_pkg::ST_READY] !== 1'b1 || rd_q[0] !== 1'b0) && n < 100);
        if (n >= 100) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    // Hardware reset, with power-on reset as well when por is set
    task automatic hw_reset(input logic por);
        nrst <= 1'b0;
        npor <= ~por;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        npor <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic wrap_up();
        error_cnt += host.hang_cnt;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        rows = '{64'h33FFFF10FFFFFFF7, 64'hC0FFFF14FFFFFFF7, 64'h43FFFF10FFFFFFFF, 64'h15FFFF0CFFFFFFDF,
                 64'hC0FFFF14FFFFFFDF, 64'h80FFFF1800020002, 64'hA5FFFF18000C0008, 64'h90FFFF1800020000,
                 64'h20FFFF0CFFFFFFFF, 64'h70D5DF08FFFFD4DF, 64'h50FFFF1800010000, 64'h12FFFF0400120012,
                 64'hC0FFFF0CFFFFFFFF, 64'h30FFFF10FFFFFFFE, 64'hD0FFFF0400120012, 64'hC0FFFF0400120000,
                 64'h70FFF90400120012, 64'hC0FFFF08FFFFD4DF, 64'h70FFFD08FFFFD4DD, 64'h70F7FF0400120012,
                 64'hB0FFFF1800010000, 64'hD1FFFF0400120000};
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        npor <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("cfg outputs", 5'b00010, cfg_o)
        `CHK("unprotected", 16'hFFFF, unprot)
        // Dyn, pers, overlay, erase, cfg, guard, refusals, freeze, soft reset
        for (int i = 0; i < 22; i++) begin
            cmd(rows[i][63:60], rows[i][59:56], rows[i][55:40]);
            host.xfer(1'b0, rows[i][39:32], 32'h0, rd_q);
            `CHK("row read", rows[i][15:0], rd_q[15:0] & rows[i][31:16])
            if (i == 9) `CHK("cfg outputs", 5'b11101, cfg_o)
        end
        `CHK("protect map", 16'hFFFE, unprot)
        `CHK("grant pulses", 1, grant_cnt)
        host.xfer(1'b0, 8'h40, 32'h0, rd_q);
        `CHK("unmapped", 33'h100000000, {host.err_q, rd_q})
        host.xfer(1'b1, spl_pkg::OFS_CFG, 32'h0, rd_q);
        host.xfer(1'b0, spl_pkg::OFS_CFG, 32'h0, rd_q);
        `CHK("cfg read-only", 16'hD4DD, rd_q[15:0])
        hw_reset(1'b0);
        host.xfer(1'b0, spl_pkg::OFS_GUARD, 32'h0, rd_q);
        `CHK("guard after reset", 1'b1, rd_q[0])
        host.xfer(1'b0, spl_pkg::OFS_DYN, 32'h0, rd_q);
        `CHK("dyn after reset", 16'hFFFF, rd_q[15:0])
        // Power cycle, then password mode; no password words are stored here
        hw_reset(1'b1);
        cmd(spl_pkg::OP_CFG_PROG, 4'h0, 16'hFFFB);
        hw_reset(1'b0);
        host.xfer(1'b0, spl_pkg::OFS_GUARD, 32'h0, rd_q);
        `CHK("pw guard reset", 1'b0, rd_q[0])
        cmd(spl_pkg::OP_UNLOCK, 4'h0, 16'hFFFF);
        host.xfer(1'b0, spl_pkg::OFS_STATUS, 32'h0, rd_q);
        `CHK("bad unlock", 2'h3, {rd_q[4], rd_q[1]})
        pw_ok <= 1'b1;
        cmd(spl_pkg::OP_UNLOCK, 4'h0, 16'hFFFF);
        host.xfer(1'b0, spl_pkg::OFS_GUARD, 32'h0, rd_q);
        `CHK("unlock", 1'b1, rd_q[0])
        cmd(spl_pkg::OP_GUARD_LOCK, 4'h0, 16'hFFFF);
        host.xfer(1'b0, spl_pkg::OFS_GUARD, 32'h0, rd_q);
        `CHK("pw guard lock", 1'b0, rd_q[0])
        wrap_up();
    end
endmodule // tb_top
